// >>> design/sdr_responder.sv
// SDI-12 sensor command responder with its reply character FIFO
`timescale 1ns/1ns

// Character FIFO with valid and ready on both sides
module sdr_fifo #(
    parameter int W = 7,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH); // Pointer index width, DEPTH a power of 2

    // Storage and pointers with one wrap bit each
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } sdr_fifo_st_t;

    sdr_fifo_st_t q; // Registered state
    sdr_fifo_st_t d; // Next state

    // Full when pointers differ only in the wrap bit
    assign in_ready = !((q.wp[AW] != q.rp[AW]) &&
                        (q.wp[AW-1:0] == q.rp[AW-1:0]));
    assign out_valid = (q.wp != q.rp);
    assign out_data = q.mem[q.rp[AW-1:0]];

    // Push and pop bookkeeping
    always_comb begin
        d = q;
        if (in_valid && in_ready) begin
            d.mem[q.wp[AW-1:0]] = in_data;
            d.wp = q.wp + 1'b1;
        end
        if (out_valid && out_ready) begin
            d.rp = q.rp + 1'b1;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : sdr_fifo

// Responder top: receiver, decoder, reply generator, transmitter
module sdr_responder #(
    parameter int BIT_CYC = sdr_pkg::BIT_CYC, // Clocks per line bit
    parameter logic [63:0] VENDOR = "XYZCORP ", // Arbitrary value
    parameter logic [47:0] MODEL = "SNS001", // Arbitrary value
    parameter int VERSION = 100, // Sensor version times hundred
    parameter int SER_LEN = 9, // Serial digits, zero omits the field
    parameter logic [103:0] SERIAL = "000000000", // Arbitrary value
    parameter int MEAS_SEC = 1, // Announced measurement time
    parameter int MEAS_CNT = 4 // Values announced per measurement
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce, // Freezes all state while low
    input wire logic sdi_i, // Data wire level as seen at the pin
    output logic sdi_o, // Data wire level driven, low is marking
    output logic sdi_oe, // High while the sensor drives the wire
    output logic meas_start, // One-cycle request to measure
    input wire logic meas_done, // One-cycle result ready
    input wire sdr_pkg::sdr_meas_t meas_val, // Result with meas_done
    output logic [6:0] cur_addr // Address now answered to
);
    localparam int CNT_W = $clog2(BIT_CYC) + 1; // Bit timer width
    localparam logic [CNT_W-1:0] FULL_BIT = CNT_W'(BIT_CYC - 1);
    localparam logic [CNT_W-1:0] HALF_BIT = CNT_W'(BIT_CYC / 2 - 1);
    localparam logic [3:0] RX_LAST = 4'h7; // Seven data plus parity
    localparam logic [3:0] TX_LAST = 4'(sdr_pkg::FRAME_BITS - 1);
    localparam logic [2:0] CMD_FULL = 3'(sdr_pkg::CMD_MAX);

    // Receiver states
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0, RX_START = 2'h1, RX_BITS = 2'h2, RX_STOP = 2'h3
    } sdr_rx_t;
    // Generator and transmitter states
    typedef enum logic {GEN_IDLE = 1'b0, GEN_RUN = 1'b1} sdr_gen_t;
    typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} sdr_tx_t;

    // Whole state of the responder outside the FIFO
    typedef struct packed {
        logic s1; // First synchroniser stage
        logic s2; // Second synchroniser stage
        sdr_rx_t rx; // Receiver state
        logic [CNT_W-1:0] rcnt; // Receiver bit timer
        logic [3:0] rbit; // Receiver bit count
        logic [7:0] rsh; // Data and parity shift register
        logic [sdr_pkg::CMD_MAX-1:0][6:0] cmd; // Command characters
        logic [2:0] clen; // Characters held
        logic bad; // Command spoiled by overflow, bad parity or missing stop bit
        sdr_gen_t gen; // Reply generator state
        sdr_pkg::sdr_kind_t kind; // Reply being produced
        logic [sdr_pkg::IDX_W-1:0] idx; // Reply character index
        sdr_tx_t tx; // Transmitter state
        logic [CNT_W-1:0] tcnt; // Transmitter bit timer
        logic [3:0] tbit; // Transmitter bit count
        logic [9:0] tsh; // Frame shift register
        logic [6:0] addr; // Own address
        logic sr_pend; // Service request owed on completion
        logic sr_due; // Completion seen, request not yet sent
        logic have; // Result held for data replies
        sdr_pkg::sdr_meas_t vals; // Held result
        logic line; // Driven line level
        logic oe; // Drive enable
        logic mstart; // Measurement start pulse
    } sdr_st_t;

    sdr_st_t q; // Registered state
    sdr_st_t d; // Next state

    logic fifo_in_ready; // FIFO has room
    logic fifo_out_valid; // FIFO holds a character
    logic [6:0] fifo_out_data; // Oldest character
    logic gen_push; // Generator offers a character
    logic tx_take; // Transmitter takes a character
    sdr_pkg::sdr_char_t gen_ch; // Character offered

    // Digit to character
    function automatic logic [6:0] dchar(input int v);
        dchar = sdr_pkg::CH_ZERO + 7'(v % 10);
    endfunction : dchar

    // Letters and digits only
    function automatic logic is_alnum(input logic [6:0] c);
        is_alnum = (c >= sdr_pkg::CH_ZERO && c <= sdr_pkg::CH_NINE) ||
                   (c >= sdr_pkg::CH_UA && c <= sdr_pkg::CH_UZ) ||
                   (c >= sdr_pkg::CH_LA && c <= sdr_pkg::CH_LZ);
    endfunction : is_alnum

    // Body length of each reply kind, address included
    function automatic int body_len(input sdr_pkg::sdr_kind_t k,
                                    input logic have);
        case (k)
            sdr_pkg::RK_ID: body_len = sdr_pkg::LEN_ID_FIX + SER_LEN;
            sdr_pkg::RK_MEAS: body_len = sdr_pkg::LEN_MEAS;
            sdr_pkg::RK_CONC: body_len = sdr_pkg::LEN_CONC;
            sdr_pkg::RK_DATA: body_len = have ? sdr_pkg::LEN_DATA
                                              : sdr_pkg::LEN_ADDR;
            default: body_len = sdr_pkg::LEN_ADDR;
        endcase
    endfunction : body_len

    // Character at position i of a reply
    function automatic sdr_pkg::sdr_char_t resp_char(
        input sdr_pkg::sdr_kind_t k, input int i, input logic [6:0] a,
        input logic have, input sdr_pkg::sdr_meas_t v);
        int n;
        int p;
        int j;
        n = body_len(k, have);
        p = 0;
        j = 0;
        resp_char.last = 1'b0;
        resp_char.ch = a; // Address opens every reply
        if (i == n) begin
            resp_char.ch = sdr_pkg::CH_CR; // Closing pair
        end else if (i > n) begin
            resp_char.ch = sdr_pkg::CH_LF;
            resp_char.last = 1'b1;
        end else if (i > 0) begin
            case (k)
                sdr_pkg::RK_ID: begin
                    if (i < sdr_pkg::ID_VEN) begin
                        resp_char.ch = (i == 1) ? sdr_pkg::CH_ONE
                                                : sdr_pkg::CH_THREE;
                    end else if (i < sdr_pkg::ID_MOD) begin
                        j = 63 - 8 * (i - sdr_pkg::ID_VEN);
                        resp_char.ch = VENDOR[j-1 -: 7];
                    end else if (i < sdr_pkg::ID_VER) begin
                        j = 47 - 8 * (i - sdr_pkg::ID_MOD);
                        resp_char.ch = MODEL[j-1 -: 7];
                    end else if (i < sdr_pkg::ID_SER) begin
                        p = sdr_pkg::ID_SER - 1 - i;
                        resp_char.ch = dchar(p == 2 ? VERSION / 100 :
                                             p == 1 ? VERSION / 10 :
                                             VERSION);
                    end else begin
                        j = 8 * (SER_LEN - 1 - (i - sdr_pkg::ID_SER));
                        resp_char.ch = SERIAL[j +: 7];
                    end
                end
                sdr_pkg::RK_MEAS, sdr_pkg::RK_CONC: begin
                    if (i == 1) begin
                        resp_char.ch = dchar(MEAS_SEC / 100);
                    end else if (i == 2) begin
                        resp_char.ch = dchar(MEAS_SEC / 10);
                    end else if (i == 3) begin
                        resp_char.ch = dchar(MEAS_SEC);
                    end else if (k == sdr_pkg::RK_CONC && i == 4) begin
                        resp_char.ch = dchar(MEAS_CNT / 10);
                    end else begin
                        resp_char.ch = dchar(MEAS_CNT);
                    end
                end
                sdr_pkg::RK_DATA: begin
                    j = (i - 1) / sdr_pkg::VAL_CHARS;
                    p = (i - 1) % sdr_pkg::VAL_CHARS;
                    if (p == 0) begin
                        resp_char.ch = v[j].neg ? sdr_pkg::CH_MINUS
                                                : sdr_pkg::CH_PLUS;
                    end else begin
                        resp_char.ch = dchar(int'(v[j].dig[4-p]));
                    end
                end
                default: resp_char.ch = a;
            endcase
        end
    endfunction : resp_char

    assign gen_ch = resp_char(q.kind, int'(q.idx), q.addr, q.have, q.vals);
    assign gen_push = (q.gen == GEN_RUN) && ce;
    assign tx_take = (q.tx == TX_IDLE) && ce;

    // Reply characters queue between generator and transmitter
    sdr_fifo #(
        .W(sdr_pkg::CW),
        .DEPTH(sdr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(gen_push),
        .in_data(gen_ch.ch),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(tx_take)
    );

    assign sdi_o = q.line;
    assign sdi_oe = q.oe;
    assign meas_start = q.mstart;
    assign cur_addr = q.addr;

    // Receive, decode, generate and transmit in one next-state process
    always_comb begin
        logic bitv; // Logical level of the wire, inverted from the pin
        logic busy; // A reply is still in flight
        logic got; // A clean character finished
        logic match; // Command names us or the wildcard
        logic [6:0] c0;
        logic [6:0] c1;
        logic [6:0] c2;
        bitv = !q.s2; // Inverted logic: pin high is a zero
        busy = (q.gen == GEN_RUN) || fifo_out_valid || (q.tx == TX_SEND);
        got = 1'b0;
        c0 = q.cmd[0];
        c1 = q.cmd[1];
        c2 = q.cmd[2];
        match = (c0 == q.addr) || (c0 == sdr_pkg::CH_QUERY);
        d = q;
        d.s1 = sdi_i;
        d.s2 = q.s1;
        d.mstart = 1'b0;
        // Receiver, listening only while no reply is in flight
        case (q.rx)
            RX_IDLE: begin
                if (!busy && !bitv) begin
                    d.rx = RX_START;
                    d.rcnt = HALF_BIT;
                end
            end
            RX_START: begin
                if (q.rcnt != '0) begin
                    d.rcnt = q.rcnt - 1'b1;
                end else if (!bitv) begin
                    d.rx = RX_BITS;
                    d.rcnt = FULL_BIT;
                    d.rbit = '0;
                end else begin
                    d.rx = RX_IDLE; // Glitch, not a start bit
                end
            end
            RX_BITS: begin
                if (q.rcnt != '0) begin
                    d.rcnt = q.rcnt - 1'b1;
                end else begin
                    d.rsh = {bitv, q.rsh[7:1]}; // Least significant first
                    d.rbit = q.rbit + 1'b1;
                    d.rcnt = FULL_BIT;
                    if (q.rbit == RX_LAST) begin
                        d.rx = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (q.rcnt != '0) begin
                    d.rcnt = q.rcnt - 1'b1;
                end else begin
                    d.rx = RX_IDLE;
                    if (bitv && !(^q.rsh)) begin
                        got = 1'b1; // Stop and even parity good
                    end else begin
                        d.bad = 1'b1;
                    end
                end
            end
            default: d.rx = RX_IDLE;
        endcase
        // Command assembly and decode at the bang
        if (got && q.rsh[6:0] == sdr_pkg::CH_BANG) begin
            d.clen = '0;
            d.bad = 1'b0;
            if (!q.bad && q.clen != '0) begin
                if (q.clen == 3'h1 && match) begin
                    d.gen = GEN_RUN; // Acknowledge and query
                    d.kind = sdr_pkg::RK_ADDR;
                end else if (q.clen == 3'h2 && match &&
                             c1 == sdr_pkg::CH_CMD_ID) begin
                    d.gen = GEN_RUN;
                    d.kind = sdr_pkg::RK_ID;
                end else if (q.clen == 3'h2 && match &&
                             (c1 == sdr_pkg::CH_CMD_MEAS ||
                              c1 == sdr_pkg::CH_CMD_CONC)) begin
                    d.gen = GEN_RUN;
                    d.kind = (c1 == sdr_pkg::CH_CMD_MEAS) ? sdr_pkg::RK_MEAS
                                                          : sdr_pkg::RK_CONC;
                    d.mstart = 1'b1;
                    d.have = 1'b0;
                    d.sr_due = 1'b0;
                    d.sr_pend = (c1 == sdr_pkg::CH_CMD_MEAS);
                end else if (q.clen == 3'h3 && match &&
                             c1 == sdr_pkg::CH_CMD_DATA &&
                             c2 == sdr_pkg::CH_ZERO) begin
                    d.gen = GEN_RUN;
                    d.kind = sdr_pkg::RK_DATA;
                end else if (q.clen == 3'h3 && c0 == q.addr &&
                             c1 == sdr_pkg::CH_CMD_ADDR && is_alnum(c2)) begin
                    d.addr = c2; // Reply below reads the new address
                    d.gen = GEN_RUN;
                    d.kind = sdr_pkg::RK_ADDR;
                end
                // Anything else stays silent, wire released
            end
            d.idx = '0;
        end else if (got) begin
            if (q.clen == CMD_FULL) begin
                d.bad = 1'b1; // Too long, drop until the bang
            end else begin
                d.cmd[q.clen] = q.rsh[6:0]; // Address comes first
                d.clen = q.clen + 1'b1;
            end
        end
        // Service request once the line is quiet
        if (q.sr_due && !busy && q.rx == RX_IDLE && d.gen == GEN_IDLE) begin
            d.gen = GEN_RUN; // Address then CR LF
            d.kind = sdr_pkg::RK_ADDR;
            d.idx = '0;
            d.sr_due = 1'b0;
            d.sr_pend = 1'b0;
        end
        // Result capture, held for data replies until the next M or C command
        if (meas_done) begin
            d.vals = meas_val;
            d.have = 1'b1;
            d.sr_due = q.sr_pend; // Set wins over the clear above
        end
        // Generator advances as the FIFO accepts characters
        if (q.gen == GEN_RUN && fifo_in_ready) begin
            d.idx = q.idx + 1'b1;
            if (gen_ch.last) begin
                d.gen = GEN_IDLE;
            end
        end
        // Transmitter, one frame per FIFO character
        case (q.tx)
            TX_IDLE: begin
                d.line = 1'b0; // Marking
                if (fifo_out_valid) begin
                    d.tsh = {1'b1, ^fifo_out_data, fifo_out_data, 1'b0};
                    d.line = 1'b1; // Start bit, inverted
                    d.tbit = '0;
                    d.tcnt = FULL_BIT;
                    d.tx = TX_SEND;
                end
            end
            TX_SEND: begin
                if (q.tcnt != '0) begin
                    d.tcnt = q.tcnt - 1'b1;
                end else if (q.tbit == TX_LAST) begin
                    d.line = 1'b0;
                    d.tx = TX_IDLE;
                end else begin
                    d.tsh = {1'b0, q.tsh[9:1]};
                    d.line = !q.tsh[1]; // Inverted logic
                    d.tbit = q.tbit + 1'b1;
                    d.tcnt = FULL_BIT;
                end
            end
            default: d.tx = TX_IDLE;
        endcase
        // Drive only while a reply is in flight
        d.oe = (d.gen == GEN_RUN) || fifo_out_valid || (d.tx == TX_SEND);
    end

    // State register, frozen while ce is low
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.addr <= sdr_pkg::ADDR_RESET; // Factory address
            q.kind <= sdr_pkg::RK_ADDR;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule : sdr_responder

// >>> include/sdr_pkg.sv
// Shared constants, character codes and carriers of the SDI-12 responder
package sdr_pkg;
    // Clock and line rate
    localparam int CLK_HZ = 250_000_000; // System clock rate in Hz
    localparam int BAUD = 1200; // Line rate in bits per second
    localparam int BIT_CYC = CLK_HZ / BAUD; // Clocks per bit, rounded down
    // Character framing
    localparam int CW = 7; // Data bits per character
    localparam int FRAME_BITS = 10; // Start, seven data, parity, stop
    localparam int CMD_MAX = 4; // Longest command body before the bang
    localparam int FIFO_DEPTH = 8; // Reply characters buffered
    localparam int IDX_W = 6; // Width of the reply character index
    localparam int SER_MAX = 13; // Longest serial number field
    localparam int NVAL = 4; // Values carried by one data reply
    localparam int VAL_CHARS = 5; // Sign and four digits per value
    // Reply body lengths, address included, CR LF excluded
    localparam int LEN_ADDR = 1;
    localparam int LEN_ID_FIX = 20;
    localparam int LEN_MEAS = 5;
    localparam int LEN_CONC = 6;
    localparam int LEN_DATA = 21;
    // Identify field start positions
    localparam int ID_VEN = 3; // Vendor field, eight characters
    localparam int ID_MOD = 11; // Model field, six characters
    localparam int ID_VER = 17; // Version field, three digits
    localparam int ID_SER = 20; // Serial number field
    // Character codes
    localparam logic [6:0] CH_BANG = 7'h21;
    localparam logic [6:0] CH_QUERY = 7'h3f;
    localparam logic [6:0] CH_CR = 7'h0d;
    localparam logic [6:0] CH_LF = 7'h0a;
    localparam logic [6:0] CH_PLUS = 7'h2b;
    localparam logic [6:0] CH_MINUS = 7'h2d;
    localparam logic [6:0] CH_ZERO = 7'h30;
    localparam logic [6:0] CH_ONE = 7'h31;
    localparam logic [6:0] CH_THREE = 7'h33;
    localparam logic [6:0] CH_NINE = 7'h39;
    localparam logic [6:0] CH_UA = 7'h41;
    localparam logic [6:0] CH_UZ = 7'h5a;
    localparam logic [6:0] CH_LA = 7'h61;
    localparam logic [6:0] CH_LZ = 7'h7a;
    localparam logic [6:0] CH_CMD_ID = 7'h49; // Identify
    localparam logic [6:0] CH_CMD_ADDR = 7'h41; // Change address
    localparam logic [6:0] CH_CMD_MEAS = 7'h4d; // Measurement
    localparam logic [6:0] CH_CMD_CONC = 7'h43; // Concurrent
    localparam logic [6:0] CH_CMD_DATA = 7'h44; // Data
    localparam logic [6:0] ADDR_RESET = 7'h30; // Factory address zero
    // Reply kinds
    typedef enum logic [2:0] {
        RK_ADDR = 3'h0, // Address then CR LF
        RK_ID = 3'h1, // Identify reply
        RK_MEAS = 3'h2, // Address, time, one-digit count
        RK_CONC = 3'h3, // Address, time, two-digit count
        RK_DATA = 3'h4 // Address and four signed values, address alone while no result is held
    } sdr_kind_t;
    // One signed value as four decimal digits, most significant first
    typedef struct packed {
        logic neg; // Minus sign when set
        logic [3:0][3:0] dig; // Digit 3 is sent first
    } sdr_val_t;
    // Vapor pressure, temperature, humidity, atmospheric pressure
    typedef sdr_val_t [NVAL-1:0] sdr_meas_t; // Index 0 sent first
    // One reply character and its end mark
    typedef struct packed {
        logic last; // Final character of the reply
        logic [6:0] ch; // Character code
    } sdr_char_t;
endpackage : sdr_pkg

// >>> tb/sdr_checker.sv
// Port assertions for the SDI-12 responder
`timescale 1ns/1ns
module sdr_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic sdi_i,
    input wire logic sdi_o,
    input wire logic sdi_oe,
    input wire logic meas_start,
    input wire logic meas_done,
    input wire sdr_pkg::sdr_meas_t meas_val,
    input wire logic [6:0] cur_addr
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_line_released: assert property (!sdi_oe |-> !sdi_o)
        else $error("line high while released");
    a_factory_addr: assert property ($rose(rst_n) |->
        cur_addr == 7'h30) else $error("address not zero after reset");
    a_addr_alnum: assert property (cur_addr inside
        {[7'h30:7'h39], [7'h41:7'h5a], [7'h61:7'h7a]})
        else $error("address not alphanumeric");
    a_change_reply: assert property ($changed(cur_addr) |->
        ##[0:8] sdi_oe) else $error("no reply to address change");
    a_start_once: assert property (meas_start |=> !meas_start)
        else $error("measure request longer than one cycle");
    a_meas_reply: assert property (meas_start |-> ##[0:8] sdi_oe)
        else $error("no reply to measurement");
    // Drive opens two marking cycles before the first start bit
    a_start_bit: assert property ($rose(sdi_oe) |->
        !sdi_o ##2 sdi_o) else $error("reply without start bit");
    a_bit_hold: assert property ($changed(sdi_o) |=>
        $stable(sdi_o)[*8]) else $error("line bit too short");
    a_stop_last: assert property ($fell(sdi_oe) |-> !$past(sdi_o, 8))
        else $error("reply released without stop bit");
    // Main scenarios reached
    c_meas: cover property (meas_start);
    c_new_addr: cover property ($changed(cur_addr));
    c_reply_end: cover property ($fell(sdi_oe));
endmodule : sdr_checker
bind sdr_responder sdr_checker i_sdr_checker (.sys_clk(sys_clk),
    .rst_n(rst_n), .ce(ce), .sdi_i(sdi_i), .sdi_o(sdi_o), .sdi_oe(sdi_oe),
    .meas_start(meas_start), .meas_done(meas_done),
    .meas_val(meas_val), .cur_addr(cur_addr));

// >>> tb/sdr_logger.sv
// Data logger model: sends commands and decodes replies
`timescale 1ns/1ns
module sdr_logger #(
    parameter int BC = 16 // Clocks per line bit
) (
    input wire logic sys_clk,
    input wire logic sdi_o,
    input wire logic sdi_oe,
    output logic sdi_i
);
    logic drv = 1'b0; // Logger drive, idle is marking low
    logic [8:0] f; // Data, parity and stop as received
    logic [7:0] rx_q[$]; // Frame good flag and character
    // Sensor owns the wire while it drives
    assign sdi_i = sdi_oe ? sdi_o : drv;
    // One character: inverted, LSB first, even parity
    task automatic put(input logic [6:0] c);
        logic [9:0] fr;
        fr = {1'b1, ^c, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            drv <= ~fr[i];
            repeat (BC) @(posedge sys_clk);
        end
    endtask : put
    // Whole command, address first
    task automatic send(input string s);
        foreach (s[i]) put(7'(s[i]));
    endtask : send
    // Reply decoder sampling mid-bit
    always begin
        @(posedge sys_clk);
        if (sdi_oe && sdi_o) begin
            repeat (BC / 2) @(posedge sys_clk);
            for (int i = 0; i < 9; i++) begin
                repeat (BC) @(posedge sys_clk);
                f[i] = ~sdi_o;
            end
            rx_q.push_back({(f[7] == ^f[6:0]) && f[8], f[6:0]});
        end
    end
endmodule : sdr_logger

// >>> tb/tb_sdr_responder.sv
// Self-checking bench for the SDI-12 responder
`timescale 1ns/1ns
module tb_sdr_responder;
    localparam int BC = 16; // Shortened bit time
    localparam string CRLF = "\015\012"; // Reply terminator
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic meas_done = 1'b0;
    logic ce = 1'b1; // Clock enable, dropped once to freeze the block
    sdr_pkg::sdr_meas_t meas_val = '0;
    logic sdi_i, sdi_o, sdi_oe, meas_start;
    logic [6:0] cur_addr;
    int fail_count = 0;
    int tests_run = 0;
    int seed = 52026;
    int starts = 0; // Measurement requests seen
    byte na; // Random new address
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (meas_start) starts <= starts + 1;
    end
    // Identity values are arbitrary
    sdr_responder #(.BIT_CYC(BC), .VENDOR("ACMEDEVS"), .MODEL("MDL007"),
        .VERSION(123), .SER_LEN(0), .MEAS_SEC(1), .MEAS_CNT(4))
    i_sdr_responder (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
        .sdi_i(sdi_i), .sdi_o(sdi_o), .sdi_oe(sdi_oe),
        .meas_start(meas_start), .meas_done(meas_done),
        .meas_val(meas_val), .cur_addr(cur_addr));
    sdr_logger #(.BC(BC)) i_sdr_logger (.sys_clk(sys_clk),
        .sdi_o(sdi_o), .sdi_oe(sdi_oe), .sdi_i(sdi_i));
    task automatic end_sim();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    task automatic cmp(input string n, input logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : cmp
    // Wait for the reply, then compare it character by character
    task automatic chk(input string e);
        int k;
        k = 0;
        while (i_sdr_logger.rx_q.size() < e.len() && k < 9000) begin
            @(posedge sys_clk);
            k++;
        end
        if (k == 9000) begin
            fail_count++;
            end_sim();
        end
        repeat (400) @(posedge sys_clk);
        cmp("reply length", 8'(e.len()), 8'(i_sdr_logger.rx_q.size()));
        foreach (e[i]) if (i < i_sdr_logger.rx_q.size())
            cmp("reply char", {1'b1, 7'(e[i])}, i_sdr_logger.rx_q[i]);
        i_sdr_logger.rx_q.delete();
    endtask : chk
    task automatic cmd(input string c, input string e);
        i_sdr_logger.send(c);
        chk(e);
    endtask : cmd
    // Result pulse to the responder
    task automatic done();
        @(posedge sys_clk) meas_done <= 1'b1;
        @(posedge sys_clk) meas_done <= 1'b0;
    endtask : done
    // Expected data body: sign and four digits per value
    function automatic string dat(input sdr_pkg::sdr_meas_t m);
        string s;
        s = "";
        for (int k = 0; k < 4; k++)
            s = {s, m[k].neg ? "-" : "+", $sformatf("%h", m[k].dig)};
        return s;
    endfunction : dat
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        cmd("0!", {"0", CRLF});
        cmd("?!", {"0", CRLF});
        cmd("?I!", {"013ACMEDEVSMDL007123", CRLF});
        cmd("?A5!", "");
        cmd("0A#!", "");
        na = 8'($unsigned($random(seed)) % 26 + 65);
        cmd($sformatf("0A%c!", na), $sformatf("%c%s", na, CRLF));
        cmp("address", 8'(na), {1'b0, cur_addr});
        cmd("0!", "");
        meas_val <= {4{1'b1, 16'h9999}};
        cmd($sformatf("%cM!", na), $sformatf("%c0014%s", na, CRLF));
        done();
        chk($sformatf("%c%s", na, CRLF));
        cmd($sformatf("%cD0!", na),
            $sformatf("%c%s%s", na, dat(meas_val), CRLF));
        for (int k = 0; k < 4; k++) begin
            meas_val[k].neg <= 1'($random(seed));
            for (int j = 0; j < 4; j++)
                meas_val[k].dig[j] <= 4'($unsigned($random(seed)) % 10);
        end
        // Short freeze on a quiet line; the block must carry on after it
        ce <= 1'b0;
        repeat (6) @(posedge sys_clk);
        ce <= 1'b1;
        cmd($sformatf("%cC!", na), $sformatf("%c00104%s", na, CRLF));
        done();
        cmd($sformatf("%cD0!", na),
            $sformatf("%c%s%s", na, dat(meas_val), CRLF));
        cmp("measure requests", 8'h02, 8'(starts));
        end_sim();
    end
endmodule : tb_sdr_responder
